// ---- core/ast_consts.svh ----
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
// byte addresses of the register words
`define AST_MODE_ADDR 8'h00
`define AST_STA_ADDR 8'h04
`define AST_TXD_ADDR 8'h08
`define AST_RXD_ADDR 8'h0c
`define AST_BRG_ADDR 8'h10
// mode register fields
`define AST_M_EN 15
`define AST_M_RTSMD 11
`define AST_M_PINSEL 8
`define AST_M_LOOP 6
`define AST_M_RXINV 4
`define AST_M_HS 3
`define AST_M_FMT 1
`define AST_M_STOP2 0
// status register fields
`define AST_S_TXISEL1 15
`define AST_S_TXINV 14
`define AST_S_TXISEL0 13
`define AST_S_RXEN 12
`define AST_S_BRK 11
`define AST_S_TXEN 10
`define AST_S_TXFULL 9
`define AST_S_TRMT 8
`define AST_S_RXISEL 6
`define AST_S_ADDEN 5
`define AST_S_RIDLE 4
`define AST_S_PARITY_ERR_FLAG 3
`define AST_S_FRAMING_ERR_FLAG 2
`define AST_S_RX_OVERRUN_FLAG 1
`define AST_S_RXDA 0
`define AST_FIFO_DEPTH 4
`define AST_BRK_ZEROS 4'd12
`define AST_TXIRQ_DELAY 2'd2
`endif

// ---- core/ast_pkg.sv ----
package ast_pkg;
   typedef enum logic [3:0] {
      AST_TX_IDLE = 4'b0001,
      AST_TX_START = 4'b0010,
      AST_TX_DATA = 4'b0100,
      AST_TX_STOP = 4'b1000
   } ast_tx_state_t;
   typedef enum logic [3:0] {
      AST_RX_IDLE = 4'b0001,
      AST_RX_START = 4'b0010,
      AST_RX_DATA = 4'b0100,
      AST_RX_STOP = 4'b1000
   } ast_rx_state_t;
   typedef struct packed {
      logic parity_err_flag;
      logic framing_err_flag;
      logic [8:0] data;
   } ast_rx_entry_t;
   typedef struct packed {
      logic tx_irq;
      logic rx_irq;
   } ast_irq_t;
endpackage

// ---- core/ast_uart.sv ----
// Summary of operation
// - transmit queue holds up to four characters ahead of the shift register
// - receive queue of four entries, each with its parity and framing flags
// - 8 or 9 data bits, even/odd/no parity with 8, one or two stops
// - baud timer is 16-bit, restarted on each transmit load, period divisor plus one
// - normal speed: bit rate is clock over 16 times divisor plus one
// - high speed: bit rate is clock over 4 times divisor plus one
// - writing the divisor clears the baud timer at once
// - enabling transmit raises transmit interrupt two cycles later
// - idle enabled transmitter loads a write into the shifter the cycle after it is queued
// - data queued while disabled starts immediately once enabled
// - break request, dummy then sync: break sent, request self-clears
// - during break the queued character only starts the frame, value dropped
// - receive interrupt when queue count reaches the selected level
// - overrun flag stays set until software clears it
// - reading receive data pops the queue with its own error flags
// - parity, framing and overrun errors each have a status flag
// - 9-bit address detect accepts only characters with ninth bit set
// - pin-use field enables clear-to-send and request-to-send pins
// - loopback feeds transmitter output back to the receiver
// - separate idle polarity inversion for transmit and receive lines
// - can drive out a clock at sixteen times the bit rate, four times at high speed
// - format 11 nine bits, 10 odd, 01 even, 00 eight bits no parity
// - break is start bit, twelve zero bits, then stop bit
// - receive interrupt at four for 11, three for 10, every char for 0x
// - transmit interrupt per transfer, on emptying transfer, or when shifted out
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"
module ast_uart
   import ast_pkg::*;
#(
   parameter int DEPTH = `AST_FIFO_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic serial_in_line,
   output logic serial_out_line,
   input wire logic clear_to_send_in,
   output logic request_to_send_out,
   output ast_irq_t irq
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
   // bus address phase capture
   logic wr_q, rd_q;
   logic [7:0] addr_q;
   wire logic take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         addr_q <= haddr;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a[7:2] == r[7:2]);
   endfunction
   wire logic wr_mode = wr_q & hit(addr_q, `AST_MODE_ADDR);
   wire logic wr_sta = wr_q & hit(addr_q, `AST_STA_ADDR);
   wire logic wr_txd = wr_q & hit(addr_q, `AST_TXD_ADDR);
   wire logic wr_brg = wr_q & hit(addr_q, `AST_BRG_ADDR);
   wire logic rd_rxd = rd_q & hit(addr_q, `AST_RXD_ADDR);
   // control registers
   logic [15:0] mode_q, brg_q;
   logic txen_q, brk_q, rxen_q, adden_q, txinv_q;
   logic [1:0] txisel_q, rxisel_q;
   logic rx_overrun_flag_q;
   wire logic en = mode_q[`AST_M_EN];
   wire logic hs = mode_q[`AST_M_HS];
   wire logic [1:0] fmt = mode_q[`AST_M_FMT +: 2];
   wire logic [1:0] pinsel = mode_q[`AST_M_PINSEL +: 2];
   wire logic nine = (fmt == 2'b11);
   wire logic par_on = (fmt == 2'b01) | (fmt == 2'b10);
   wire logic par_odd = (fmt == 2'b10);
   logic brk_done;
   logic rx_push_ovf;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= 16'h0000;
         brg_q <= 16'h0000;
         txen_q <= 1'b0;
         brk_q <= 1'b0;
         rxen_q <= 1'b0;
         adden_q <= 1'b0;
         txinv_q <= 1'b0;
         txisel_q <= 2'b00;
         rxisel_q <= 2'b00;
         rx_overrun_flag_q <= 1'b0;
      end else begin
         if (wr_mode)
            mode_q <= hwdata[15:0];
         if (wr_brg)
            brg_q <= hwdata[15:0];
         if (wr_sta) begin
            txen_q <= hwdata[`AST_S_TXEN];
            rxen_q <= hwdata[`AST_S_RXEN];
            adden_q <= hwdata[`AST_S_ADDEN];
            txinv_q <= hwdata[`AST_S_TXINV];
            txisel_q <= {hwdata[`AST_S_TXISEL1], hwdata[`AST_S_TXISEL0]};
            rxisel_q <= hwdata[`AST_S_RXISEL +: 2];
         end
         // hardware clear of the break request wins over a rewrite
         if (brk_done)
            brk_q <= 1'b0;
         else if (wr_sta)
            brk_q <= hwdata[`AST_S_BRK];
         // overflow set wins over software clear
         if (rx_push_ovf)
            rx_overrun_flag_q <= 1'b1;
         else if (wr_sta && !hwdata[`AST_S_RX_OVERRUN_FLAG])
            rx_overrun_flag_q <= 1'b0;
      end
   end
   // baud generator: one tick per oversample slot
   logic [15:0] brg_cnt_q;
   wire logic brg_tick = (brg_cnt_q == brg_q);
   logic tx_go;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         brg_cnt_q <= 16'h0000;
      else if (wr_brg || !en || tx_go)
         brg_cnt_q <= 16'h0000;
      else if (brg_tick)
         brg_cnt_q <= 16'h0000;
      else
         brg_cnt_q <= brg_cnt_q + 16'h0001;
   end
   // oversample phase: 16 or 4 slots per bit
   wire logic [3:0] ovs_last = hs ? 4'd3 : 4'd15;
   wire logic [3:0] ovs_mid = hs ? 4'd1 : 4'd7;
   logic clk16_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         clk16_q <= 1'b0;
      // high for the first half of each tick period, so one cycle per oversample slot;
      // at divisor 0 a tick is one clock long and the output simply stays high
      else
         clk16_q <= (brg_cnt_q <= {1'b0, brg_q[15:1]});
   end
   // transmit queue
   logic [8:0] txf_mem [DEPTH];
   logic [AW-1:0] txf_wp_q, txf_rp_q;
   logic [AW:0] txf_cnt_q;
   wire logic txf_full = (txf_cnt_q == DEPTH_C);
   wire logic txf_empty = (txf_cnt_q == '0);
   wire logic txf_push = wr_txd & ~txf_full;
   // only the write that drops transmit enable flushes; words queued while off wait for enable
   wire logic tx_off = wr_sta & txen_q & ~hwdata[`AST_S_TXEN];
   ast_tx_state_t tx_st_q;
   logic [3:0] tx_ph_q, tx_bit_q;
   logic [10:0] tx_sh_q;
   logic tx_line_q, tx_brk_q;
   wire logic cts_gate = (pinsel == 2'b10) & ~mode_q[`AST_M_RTSMD] & clear_to_send_in;
   wire logic tx_idle = (tx_st_q == AST_TX_IDLE);
   assign tx_go = tx_idle & en & txen_q & ~txf_empty & ~cts_gate;
   wire logic [8:0] tx_head = txf_mem[txf_rp_q];
   wire logic tx_par = ^tx_head[7:0] ^ par_odd;
   wire logic [3:0] tx_nbits = brk_q ? `AST_BRK_ZEROS : ((nine | par_on) ? 4'd9 : 4'd8);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txf_wp_q <= '0;
         txf_rp_q <= '0;
         txf_cnt_q <= '0;
      end else if (tx_off) begin
         txf_wp_q <= '0;
         txf_rp_q <= '0;
         txf_cnt_q <= {(AW + 1){1'b0}};
      end else begin
         if (txf_push)
            txf_wp_q <= txf_wp_q + AW'(1);
         if (tx_go)
            txf_rp_q <= txf_rp_q + AW'(1);
         txf_cnt_q <= txf_cnt_q + (AW + 1)'(txf_push) - (AW + 1)'(tx_go);
      end
   end
   always_ff @(posedge hclk) begin
      if (txf_push)
         txf_mem[txf_wp_q] <= hwdata[8:0];
   end
   // transmit shifter; start bit comes out one tick after the load
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_st_q <= AST_TX_IDLE;
         tx_ph_q <= 4'd0;
         tx_bit_q <= 4'd0;
         tx_sh_q <= 11'h000;
         tx_line_q <= 1'b1;
         tx_brk_q <= 1'b0;
      end else if (!txen_q) begin
         tx_st_q <= AST_TX_IDLE;
         tx_line_q <= 1'b1;
         tx_brk_q <= 1'b0;
      end else begin
         unique case (tx_st_q)
            AST_TX_IDLE: begin
               if (tx_go) begin
                  tx_brk_q <= brk_q;
                  // break frames discard the queued value
                  tx_sh_q <= brk_q ? 11'h000 : {2'b00, par_on ? tx_par : tx_head[8],
                     tx_head[7:0]};
                  tx_bit_q <= tx_nbits;
                  tx_ph_q <= 4'd0;
                  tx_st_q <= AST_TX_START;
               end
            end
            AST_TX_START: begin
               if (brg_tick) begin
                  tx_line_q <= 1'b0;
                  tx_ph_q <= tx_ph_q + 4'd1;
                  if (tx_ph_q == ovs_last) begin
                     tx_ph_q <= 4'd0;
                     tx_st_q <= AST_TX_DATA;
                  end
               end
            end
            AST_TX_DATA: begin
               if (brg_tick) begin
                  tx_line_q <= tx_sh_q[0];
                  tx_ph_q <= tx_ph_q + 4'd1;
                  if (tx_ph_q == ovs_last) begin
                     tx_ph_q <= 4'd0;
                     tx_sh_q <= {1'b0, tx_sh_q[10:1]};
                     tx_bit_q <= tx_bit_q - 4'd1;
                     if (tx_bit_q == 4'd1) begin
                        tx_st_q <= AST_TX_STOP;
                        tx_bit_q <= mode_q[`AST_M_STOP2] ? 4'd2 : 4'd1;
                     end
                  end
               end
            end
            AST_TX_STOP: begin
               if (brg_tick) begin
                  tx_line_q <= 1'b1;
                  tx_ph_q <= tx_ph_q + 4'd1;
                  if (tx_ph_q == ovs_last) begin
                     tx_ph_q <= 4'd0;
                     tx_bit_q <= tx_bit_q - 4'd1;
                     if (tx_bit_q == 4'd1 || tx_brk_q)
                        tx_st_q <= AST_TX_IDLE;
                  end
               end
            end
         endcase
      end
   end
   assign brk_done = (tx_st_q == AST_TX_STOP) & tx_brk_q & brg_tick & (tx_ph_q == ovs_last);
   wire logic trmt = tx_idle & txf_empty;
   wire logic tx_line_raw = tx_idle ? 1'b1 : tx_line_q;
   // transmit interrupt sources
   logic [1:0] txen_dly_q;
   logic trmt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txen_dly_q <= 2'b00;
         trmt_q <= 1'b1;
      end else begin
         txen_dly_q <= {txen_dly_q[0], wr_sta & hwdata[`AST_S_TXEN] & ~txen_q};
         trmt_q <= trmt;
      end
   end
   wire logic tx_last_out = trmt & ~trmt_q;
   wire logic tx_empty_xfer = tx_go & (txf_cnt_q == (AW + 1)'(1));
   logic tx_irq_d;
   always_comb begin
      unique case (txisel_q)
         2'b01: tx_irq_d = tx_last_out;
         2'b10: tx_irq_d = tx_empty_xfer;
         default: tx_irq_d = tx_go;
      endcase
   end
   // receiver
   wire logic rx_pin = (mode_q[`AST_M_LOOP] ? tx_line_raw : serial_in_line)
      ^ mode_q[`AST_M_RXINV];
   logic rx_prev_q;
   ast_rx_state_t rx_st_q;
   logic [3:0] rx_ph_q, rx_bit_q;
   logic [8:0] rx_sh_q;
   logic rx_done;
   logic rx_framing_err_flag;
   ast_rx_entry_t rxf_mem [DEPTH];
   logic [AW-1:0] rxf_wp_q, rxf_rp_q;
   logic [AW:0] rxf_cnt_q;
   wire logic [3:0] rx_nbits = (nine | par_on) ? 4'd9 : 4'd8;
   wire logic rx_parity_err_flag = par_on & (^rx_sh_q[8:0] ^ par_odd);
   wire logic rx_accept = ~(nine & adden_q) | rx_sh_q[8];
   wire logic [8:0] rx_data = nine ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
   wire logic rxf_full = (rxf_cnt_q == DEPTH_C);
   wire logic rx_store = rx_done & rx_accept;
   wire logic rxf_push = rx_store & ~rxf_full;
   assign rx_push_ovf = rx_store & rxf_full;
   wire logic rxf_pop = rd_rxd & (rxf_cnt_q != '0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_prev_q <= 1'b1;
         rx_st_q <= AST_RX_IDLE;
         rx_ph_q <= 4'd0;
         rx_bit_q <= 4'd0;
         rx_sh_q <= 9'h000;
      end else begin
         rx_prev_q <= rx_pin;
         unique case (rx_st_q)
            AST_RX_IDLE: begin
               if (en && rxen_q && rx_prev_q && !rx_pin) begin
                  rx_ph_q <= 4'd0;
                  rx_st_q <= AST_RX_START;
               end
            end
            AST_RX_START: begin
               if (brg_tick) begin
                  rx_ph_q <= rx_ph_q + 4'd1;
                  if (rx_ph_q == ovs_mid) begin
                     rx_ph_q <= 4'd0;
                     rx_bit_q <= rx_nbits;
                     rx_st_q <= rx_pin ? AST_RX_IDLE : AST_RX_DATA;
                  end
               end
            end
            AST_RX_DATA: begin
               if (brg_tick) begin
                  rx_ph_q <= rx_ph_q + 4'd1;
                  if (rx_ph_q == ovs_last) begin
                     rx_ph_q <= 4'd0;
                     rx_sh_q <= rx_nbits == 4'd9 ? {rx_pin, rx_sh_q[8:1]}
                        : {1'b0, rx_pin, rx_sh_q[7:1]};
                     rx_bit_q <= rx_bit_q - 4'd1;
                     if (rx_bit_q == 4'd1)
                        rx_st_q <= AST_RX_STOP;
                  end
               end
            end
            AST_RX_STOP: begin
               if (brg_tick) begin
                  rx_ph_q <= rx_ph_q + 4'd1;
                  if (rx_ph_q == ovs_last)
                     rx_st_q <= AST_RX_IDLE;
               end
            end
         endcase
      end
   end
   assign rx_done = (rx_st_q == AST_RX_STOP) & brg_tick & (rx_ph_q == ovs_last);
   assign rx_framing_err_flag = ~rx_pin;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxf_wp_q <= '0;
         rxf_rp_q <= '0;
         rxf_cnt_q <= '0;
      end else begin
         if (rxf_push)
            rxf_wp_q <= rxf_wp_q + AW'(1);
         if (rxf_pop)
            rxf_rp_q <= rxf_rp_q + AW'(1);
         rxf_cnt_q <= rxf_cnt_q + (AW + 1)'(rxf_push) - (AW + 1)'(rxf_pop);
      end
   end
   always_ff @(posedge hclk) begin
      if (rxf_push)
         rxf_mem[rxf_wp_q] <= '{parity_err_flag: rx_parity_err_flag, framing_err_flag: rx_framing_err_flag, data: rx_data};
   end
   wire ast_rx_entry_t rx_head = (rxf_cnt_q != '0) ? rxf_mem[rxf_rp_q] : '0;
   // receive level interrupt, evaluated on each store
   wire logic [AW:0] rx_lvl = (rxisel_q == 2'b11) ? DEPTH_C
      : (rxisel_q == 2'b10) ? DEPTH_C - (AW + 1)'(1) : (AW + 1)'(1);
   wire logic rx_irq_d = rxf_push & ((rxf_cnt_q + (AW + 1)'(1)) >= rx_lvl);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= '0;
      else begin
         irq.tx_irq <= tx_irq_d | txen_dly_q[1];
         irq.rx_irq <= rx_irq_d;
      end
   end
   // pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_out_line <= 1'b1;
         request_to_send_out <= 1'b1;
      end else begin
         serial_out_line <= tx_line_raw ^ txinv_q;
         unique case (pinsel)
            2'b11: request_to_send_out <= en & clk16_q;
            2'b01, 2'b10: request_to_send_out <= mode_q[`AST_M_RTSMD] ? ~tx_idle : rxf_full;
            default: request_to_send_out <= 1'b1;
         endcase
      end
   end
   // read mux
   wire logic [15:0] sta_rd = {txisel_q[1], txinv_q, txisel_q[0], rxen_q, brk_q, txen_q,
      txf_full, trmt, rxisel_q, adden_q, rx_st_q == AST_RX_IDLE, rx_head.parity_err_flag,
      rx_head.framing_err_flag, rx_overrun_flag_q, rxf_cnt_q != '0};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite) begin
         if (hit(haddr, `AST_MODE_ADDR))
            hrdata <= {16'h0000, mode_q};
         else if (hit(haddr, `AST_STA_ADDR))
            hrdata <= {16'h0000, sta_rd};
         else if (hit(haddr, `AST_RXD_ADDR))
            hrdata <= {23'h000000, rx_head.data};
         else if (hit(haddr, `AST_BRG_ADDR))
            hrdata <= {16'h0000, brg_q};
         else
            hrdata <= 32'h0000_0000;
      end
   end
   chk_txen_irq_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_sta && hwdata[`AST_S_TXEN] && !txen_q) |-> ##3 irq.tx_irq)
      else $error("tx irq not two cycles after enable");
   chk_brg_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_brg |=> brg_cnt_q == 16'h0000)
      else $error("baud timer not cleared on write");
   chk_rx_overrun_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      (rx_overrun_flag_q && !(wr_sta && !hwdata[`AST_S_RX_OVERRUN_FLAG])) |=> rx_overrun_flag_q)
      else $error("overrun flag dropped");
   chk_ovf_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_push_ovf |=> rx_overrun_flag_q)
      else $error("overrun not flagged");
   chk_txf_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      txf_cnt_q <= DEPTH_C)
      else $error("tx queue over depth");
   chk_rxf_pop: assert property (@(posedge hclk) disable iff (!hresetn)
      (rxf_pop && !rxf_push) |=> rxf_cnt_q == $past(rxf_cnt_q) - (AW + 1)'(1))
      else $error("rx read did not pop");
   chk_brk_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      brk_done |=> !brk_q)
      else $error("break request not cleared");
   chk_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
      (tx_st_q == AST_TX_START && tx_ph_q != 4'd0 && txen_q)
      |-> ##1 serial_out_line == txinv_q)
      else $error("start bit not low");
   chk_go_start: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_go |=> tx_st_q == AST_TX_START)
      else $error("load did not start frame");
   cov_tx_frame: cover property (@(posedge hclk) tx_go ##[1:1000] trmt);
   cov_rx_store: cover property (@(posedge hclk) rxf_push);
   cov_break: cover property (@(posedge hclk) brk_done);
   cov_ovf: cover property (@(posedge hclk) rx_push_ovf);
endmodule
`default_nettype wire

// ---- tb/ast_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ast_line_model #(
   parameter int BIT = 16
) (
   input wire logic hclk,
   input wire logic tx_line,
   output logic rx_line
);
   initial rx_line = 1'b1;
   // low start, lsb first, caller picks stop level to force framing faults
   task automatic send(input logic [8:0] d, input int n, input logic stop);
      rx_line <= 1'b0;
      repeat (BIT) @(posedge hclk);
      for (int i = 0; i < n; i++) begin
         rx_line <= d[i];
         repeat (BIT) @(posedge hclk);
      end
      rx_line <= stop;
      repeat (BIT) @(posedge hclk);
      rx_line <= 1'b1;
      repeat (BIT) @(posedge hclk);
   endtask
   // samples bit centres; unknown result on timeout or low stop
   task automatic recv(output logic [11:0] d, input int n);
      int t;
      d = 'x;
      t = 0;
      while (tx_line === 1'b1 && t < 3000) begin
         @(posedge hclk);
         t++;
      end
      if (t < 3000) begin
         repeat (BIT / 2) @(posedge hclk);
         for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge hclk);
            d[i] = tx_line;
         end
         repeat (BIT) @(posedge hclk);
         if (tx_line !== 1'b1) d = 'x;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/test_ast_uart.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"
module test_ast_uart;
   import ast_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   logic hreadyout, hresp, rx_line, tx_line, rts;
   logic [11:0] d;
   ast_irq_t irq;
   int fails = 0, compares = 0;
   int txi = 0, rxi = 0;
   always #4 hclk = ~hclk;
   // interrupt outputs are one-cycle pulses, so count them
   always @(posedge hclk) begin
      if (irq.tx_irq === 1'b1) txi <= txi + 1;
      if (irq.rx_irq === 1'b1) rxi <= rxi + 1;
   end
   ast_uart ast_uart_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_in_line(rx_line),
      .serial_out_line(tx_line), .clear_to_send_in(1'b0), .request_to_send_out(rts), .irq(irq));
   ast_line_model ast_line_model_i (.hclk(hclk), .tx_line(tx_line), .rx_line(rx_line));
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_ready();
      int t;
      t = 0;
      do begin
         @(posedge hclk);
         t++;
      end while (hreadyout !== 1'b1 && t < 100);
      if (t >= 100) begin
         fails++;
         final_report();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      check(r & mask, exp);
   endtask
   localparam logic [31:0] ENA = 32'h1 << `AST_M_EN;
   localparam logic [31:0] RUN = (32'h1 << `AST_S_RXEN) | (32'h1 << `AST_S_TXEN);
   initial begin
      int t;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      check({31'h0, tx_line}, 32'h1);
      // divisor 0 gives 16 clocks per bit at normal speed
      bus(`AST_BRG_ADDR, 1'b1, 32'h0);
      bus(`AST_MODE_ADDR, 1'b1, ENA);
      bus(`AST_STA_ADDR, 1'b1, RUN);
      t = 0;
      while (irq.tx_irq !== 1'b1 && t < 6) begin
         @(posedge hclk);
         t++;
      end
      check(t < 6, 1);
      fork
         ast_line_model_i.recv(d, 8);
         bus(`AST_TXD_ADDR, 1'b1, 32'ha5);
      join
      check(d[7:0], 8'ha5);
      // break request: dummy value is dropped, sync follows the break
      bus(`AST_STA_ADDR, 1'b1, RUN | (32'h1 << `AST_S_BRK));
      bus(`AST_TXD_ADDR, 1'b1, 32'h3c);
      fork
         ast_line_model_i.recv(d, 12);
         bus(`AST_TXD_ADDR, 1'b1, 32'h55);
      join
      check(d, 12'h000);
      ast_line_model_i.recv(d, 8);
      check(d[7:0], 8'h55);
      check(txi, 4);
      rd(`AST_STA_ADDR, 32'h1 << `AST_S_BRK, 0);
      // five arrivals into a four-deep queue force an overrun; rts follows a full queue
      bus(`AST_MODE_ADDR, 1'b1, ENA | (32'h1 << `AST_M_PINSEL));
      bus(`AST_STA_ADDR, 1'b1, RUN | (32'h3 << `AST_S_RXISEL));
      for (int i = 1; i <= 5; i++) ast_line_model_i.send(9'(i * 17), 8, 1'b1);
      rd(`AST_STA_ADDR, 32'h3, 32'h3);
      check(rxi, 1);
      check({31'h0, rts}, 32'h1);
      for (int i = 1; i <= 4; i++) rd(`AST_RXD_ADDR, 32'hff, i * 17);
      rd(`AST_STA_ADDR, 32'h2, 32'h2);
      bus(`AST_STA_ADDR, 1'b1, RUN);
      rd(`AST_STA_ADDR, 32'h3, 32'h0);
      check({31'h0, rts}, 32'h0);
      // even parity: 0x01 needs parity one, send zero
      bus(`AST_MODE_ADDR, 1'b1, ENA | (32'h1 << `AST_M_FMT));
      ast_line_model_i.send(9'h001, 9, 1'b1);
      ast_line_model_i.send(9'h003, 9, 1'b0);
      rd(`AST_STA_ADDR, 32'hc, 32'h8);
      rd(`AST_RXD_ADDR, 32'hff, 32'h01);
      rd(`AST_STA_ADDR, 32'hc, 32'h4);
      rd(`AST_RXD_ADDR, 32'hff, 32'h03);
      check(rxi, 3);
      // 9-bit loopback: two words queued while transmit is off, only the address one kept
      bus(`AST_MODE_ADDR, 1'b1, ENA | (32'h1 << `AST_M_LOOP) | (32'h3 << `AST_M_FMT));
      bus(`AST_STA_ADDR, 1'b1, 32'h1 << `AST_S_RXEN);
      bus(`AST_TXD_ADDR, 1'b1, 32'h1a5);
      bus(`AST_TXD_ADDR, 1'b1, 32'h05a);
      fork
         ast_line_model_i.recv(d, 9);
         bus(`AST_STA_ADDR, 1'b1, RUN | (32'h1 << `AST_S_ADDEN) | (32'h1 << `AST_S_TXISEL0));
      join
      check(d[8:0], 9'h1a5);
      ast_line_model_i.recv(d, 9);
      check(d[8:0], 9'h05a);
      rd(`AST_RXD_ADDR, 32'h1ff, 32'h1a5);
      rd(`AST_STA_ADDR, 32'h1, 32'h0);
      repeat (16) @(posedge hclk);
      check(txi, 6);
      check(rxi, 4);
      bus(`AST_STA_ADDR, 1'b1, RUN | (32'h1 << `AST_S_TXINV));
      repeat (2) @(posedge hclk);
      check({31'h0, tx_line}, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
